// ---- hw/scs_pkg.sv ----
// package of constants and types for the system clock source select block
package scs_pkg;
  // register bus
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] OSC_CTRL_OFS = 4'h0;
  localparam logic [3:0] CLK_DIV_OFS = 4'h1;
  localparam logic [3:0] TUNE_OFS = 4'h2;
  localparam logic [3:0] MODE_STAT_OFS = 4'h3;
  // oscillator control register fields
  localparam int CUR_SEL_LSB = 12;
  localparam int NEW_SEL_LSB = 8;
  localparam int FAIL_BIT = 3;
  localparam int SEC_EN_BIT = 1;
  localparam int SWITCH_BIT = 0;
  // clock divisor and tune register fields
  localparam int POST_SEL_LSB = 8;
  localparam logic [2:0] POST_SEL_RST = 3'h0;
  localparam int TUNE_W = 6;
  localparam logic [5:0] TUNE_RST = 6'h00;
  // erased configuration selects fast rc with divide-by-n
  localparam logic [2:0] INIT_SEL_ERASED = 3'h7;
  localparam logic [1:0] PRI_MODE_ERASED = 2'h3;
  // nominal source frequencies and instruction clock limit in khz
  localparam int FAST_RC_KHZ = 7370;
  localparam int LOW_POWER_RC_KHZ = 32;
  localparam int MAX_INSTR_KHZ = 40000;
  // clock fail monitor: reference edges without an oscillator edge
  localparam logic [3:0] FAIL_LIMIT = 4'h4;
  // oscillator source selects
  localparam logic [2:0] SEL_FRC = 3'h0;
  localparam logic [2:0] SEL_FRC_PLL = 3'h1;
  localparam logic [2:0] SEL_PRI = 3'h2;
  localparam logic [2:0] SEL_PRI_PLL = 3'h3;
  localparam logic [2:0] SEL_SEC = 3'h4;
  localparam logic [2:0] SEL_LOW_POWER_RC_OSC = 3'h5;
  localparam logic [2:0] SEL_FRC_DIV16 = 3'h6;
  localparam logic [2:0] SEL_FRC_DIVN = 3'h7;
  // primary oscillator modes
  localparam logic [1:0] PRI_EXT = 2'h0;
  localparam logic [1:0] PRI_STD = 2'h1;
  localparam logic [1:0] PRI_HS = 2'h2;
  // the twelve clock modes, one-hot
  typedef enum logic [11:0] {
    CM_FRC = 12'h001,
    CM_FRC_PLL = 12'h002,
    CM_EXT = 12'h004,
    CM_STD = 12'h008,
    CM_HS = 12'h010,
    CM_EXT_PLL = 12'h020,
    CM_STD_PLL = 12'h040,
    CM_HS_PLL = 12'h080,
    CM_SEC = 12'h100,
    CM_LOW_POWER_RC_OSC = 12'h200,
    CM_FRC_DIV16 = 12'h400,
    CM_FRC_DIVN = 12'h800
  } scs_mode_type;
endpackage

// ---- hw/scs_postscaler.sv ----
// fast rc postscaler: divides the fast rc enable stream by 1..256
`timescale 1ns/1ns
module scs_postscaler
  import scs_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_tick,
  input wire logic [2:0] i_sel,
  // output pulse
  output logic o_tick
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [7:0] limit;

  // terminal count for the selected factor
  function automatic logic [7:0] post_limit(input logic [2:0] sel);
    if (sel == 3'h7)
    begin
      post_limit = 8'hff;
    end
    else
    begin
      post_limit = 8'((9'h001 << sel) - 9'h001);
    end
  endfunction

  always_comb
  begin
    limit = post_limit(i_sel);
    cnt_nxt = cnt_r;
    o_tick = 1'b0;
    if (i_tick)
    begin
      if (cnt_r >= limit)
      begin
        cnt_nxt = 8'h00;
        o_tick = 1'b1;
      end
      else
      begin
        cnt_nxt = cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      cnt_r <= 8'h00;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule // scs_postscaler

// ---- hw/scs_instr_div.sv ----
// divide-by-two instruction clock stage
`timescale 1ns/1ns
module scs_instr_div
  import scs_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // oscillator tick in
  input wire logic i_tick,
  // instruction clock out
  output logic o_clk,
  output logic o_tick
);
  logic tog_r;
  logic tog_nxt;

  always_comb
  begin
    tog_nxt = i_tick ? ~tog_r : tog_r;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      tog_r <= 1'b0;
    end
    else
    begin
      tog_r <= tog_nxt;
    end
  end

  assign o_clk = tog_r;
  assign o_tick = i_tick & tog_r;

  // equal high and low time in oscillator ticks
  chk_toggle_on_tick: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_tick |=> (tog_r != $past(tog_r)))
    else $error("instruction clock did not toggle");
endmodule // scs_instr_div

// ---- hw/scs_top.sv ----
// system clock source select: mode decode, selection, fail monitor, registers
// ==========
// Summary of operation
// - seven clock sources are offered, fast rc, fast rc pll, primary, primary pll, sec, low_power_rc_osc, postscaled.
// - a three-bit postscaler field divides the fast rc clock from 1:1 up to 1:256.
// - the fast rc runs at a nominal 7.37 MHz and has a software tuning value.
// - the primary oscillator runs as standard crystal, high-speed crystal or external clock.
// - the low-power rc clock also feeds the watchdog and the clock fail monitor.
// - only fast rc and primary can be routed through the pll, as the mode selects.
// - at power-on the initial select and primary mode configuration fields pick the source.
// - erased configuration bits give the fast rc with divide-by-n as power-on source.
// - every configuration combination decodes to exactly one of twelve clock modes.
// - the instruction clock is the selected oscillator clock divided by two.
// - a fail monitor detects a stopped clock and falls back; sources can switch at run time.
// - select codes 000..111 and primary mode codes 00 ext, 01 std, 10 hs decode as listed.
`timescale 1ns/1ns
module scs_top
  import scs_pkg::*;
(
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  // oscillator ticks, asynchronous levels from the analog sources
  input wire logic I_FAST_RC_OSC,
  input wire logic I_FAST_RC_PLL,
  input wire logic I_PRIMARY_OSC,
  input wire logic I_PRIMARY_PLL,
  input wire logic I_SECONDARY_LOW_POWER_OSC,
  input wire logic I_LOW_POWER_RC_OSC,
  // nonvolatile configuration
  input wire logic [2:0] I_INITIAL_OSC_SEL,
  input wire logic [1:0] I_PRIMARY_OSC_MODE_SEL,
  // register port
  input wire logic [ADDR_W-1:0] I_ADDR,
  input wire logic [DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [DATA_W-1:0] O_RDATA,
  // clock outputs
  output logic O_OSC_TICK,
  output logic O_INSTR_CLK,
  output logic O_INSTR_TICK,
  output logic O_WDT_REF_TICK,
  output logic O_FAIL_REF_TICK,
  output logic O_PLL_IN_SEL_PRI,
  output logic O_PLL_EN,
  output logic [1:0] O_PRI_MODE,
  output logic [TUNE_W-1:0] O_FAST_RC_TUNE,
  output logic O_SEC_OSC_EN
);
  // ==========
  // input synchronisers
  logic [5:0] osc_in;
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic [5:0] prev_r;
  logic [5:0] rise;
  assign osc_in = {I_LOW_POWER_RC_OSC, I_SECONDARY_LOW_POWER_OSC, I_PRIMARY_PLL,
                   I_PRIMARY_OSC, I_FAST_RC_PLL, I_FAST_RC_OSC};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_sync
      always_ff @(posedge I_REF_CLK)
      begin
        if (!I_RST_N)
        begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          prev_r[gi] <= 1'b0;
        end
        else
        begin
          sync1_r[gi] <= osc_in[gi];
          sync2_r[gi] <= sync1_r[gi];
          prev_r[gi] <= sync2_r[gi];
        end
      end
      assign rise[gi] = sync2_r[gi] & ~prev_r[gi];
    end
  endgenerate

  // ==========
  // configuration decode
  // unique mode decode
  function automatic scs_mode_type decode_mode(input logic [2:0] sel, input logic [1:0] pm);
    logic [1:0] m;
    m = (pm == PRI_HS) ? PRI_HS : ((pm == PRI_STD) ? PRI_STD : PRI_EXT);
    case (sel)
      SEL_FRC: decode_mode = CM_FRC;
      SEL_FRC_PLL: decode_mode = CM_FRC_PLL;
      SEL_PRI: decode_mode = (m == PRI_HS) ? CM_HS : ((m == PRI_STD) ? CM_STD : CM_EXT);
      SEL_PRI_PLL:
        decode_mode = (m == PRI_HS) ? CM_HS_PLL : ((m == PRI_STD) ? CM_STD_PLL : CM_EXT_PLL);
      SEL_SEC: decode_mode = CM_SEC;
      SEL_LOW_POWER_RC_OSC: decode_mode = CM_LOW_POWER_RC_OSC;
      SEL_FRC_DIV16: decode_mode = CM_FRC_DIV16;
      default: decode_mode = CM_FRC_DIVN;
    endcase
  endfunction

  // ==========
  // oscillator control state
  logic [2:0] cur_sel_r, cur_sel_nxt;
  logic [2:0] new_sel_r, new_sel_nxt;
  logic [1:0] pri_mode_r, pri_mode_nxt;
  logic [2:0] post_sel_r, post_sel_nxt;
  logic [TUNE_W-1:0] tune_r, tune_nxt;
  logic fail_r, fail_nxt;
  logic sec_en_r, sec_en_nxt;
  logic switch_r, switch_nxt;
  logic por_done_r, por_done_nxt;
  logic [3:0] miss_r, miss_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  scs_mode_type mode;
  logic osc_tick;
  logic frc_post_tick;
  logic div16_tick;
  logic fail_event;
  logic wr_osc;

  assign mode = decode_mode(cur_sel_r, pri_mode_r);
  assign wr_osc = I_WR && (I_ADDR == OSC_CTRL_OFS);

  scs_postscaler u_post (
    .i_clk(I_REF_CLK),
    .i_rst_n(I_RST_N),
    .i_tick(rise[0]),
    .i_sel(post_sel_r),
    .o_tick(frc_post_tick)
  );

  scs_postscaler u_div16 (
    .i_clk(I_REF_CLK),
    .i_rst_n(I_RST_N),
    .i_tick(rise[0]),
    .i_sel(3'h4),
    .o_tick(div16_tick)
  );

  always_comb
  begin
    case (mode)
      CM_FRC: osc_tick = rise[0];
      // pll only behind fast rc and primary
      CM_FRC_PLL: osc_tick = rise[1];
      CM_EXT, CM_STD, CM_HS: osc_tick = rise[2];
      CM_EXT_PLL, CM_STD_PLL, CM_HS_PLL: osc_tick = rise[3];
      CM_SEC: osc_tick = rise[4];
      CM_LOW_POWER_RC_OSC: osc_tick = rise[5];
      CM_FRC_DIV16: osc_tick = div16_tick;
      default: osc_tick = frc_post_tick;
    endcase
  end

  scs_instr_div u_instr (
    .i_clk(I_REF_CLK),
    .i_rst_n(I_RST_N),
    .i_tick(osc_tick),
    .o_clk(O_INSTR_CLK),
    .o_tick(O_INSTR_TICK)
  );

  // missing-edge monitor on the low-power rc reference
  assign fail_event = rise[5] && !osc_tick && (miss_r == FAIL_LIMIT - 4'h1);

  always_comb
  begin
    cur_sel_nxt = cur_sel_r;
    new_sel_nxt = new_sel_r;
    pri_mode_nxt = pri_mode_r;
    post_sel_nxt = post_sel_r;
    tune_nxt = tune_r;
    fail_nxt = fail_r;
    sec_en_nxt = sec_en_r;
    switch_nxt = 1'b0;
    por_done_nxt = 1'b1;
    miss_nxt = miss_r;
    rdata_nxt = '0;
    if (!por_done_r)
    begin
      // latch configuration at release of reset
      cur_sel_nxt = I_INITIAL_OSC_SEL;
      new_sel_nxt = I_INITIAL_OSC_SEL;
      // one primary mode, reserved code falls to standard crystal
      pri_mode_nxt = (I_PRIMARY_OSC_MODE_SEL == 2'h3) ? PRI_STD : I_PRIMARY_OSC_MODE_SEL;
    end
    else
    begin
      if (osc_tick)
      begin
        miss_nxt = 4'h0;
      end
      else if (rise[5] && miss_r < FAIL_LIMIT)
      begin
        miss_nxt = miss_r + 4'h1;
      end
      if (wr_osc)
      begin
        new_sel_nxt = I_WDATA[NEW_SEL_LSB +: 3];
        sec_en_nxt = I_WDATA[SEC_EN_BIT];
        // software clears the fail flag by writing zero
        if (!I_WDATA[FAIL_BIT])
        begin
          fail_nxt = 1'b0;
        end
        if (I_WDATA[SWITCH_BIT])
        begin
          cur_sel_nxt = I_WDATA[NEW_SEL_LSB +: 3];
          switch_nxt = 1'b1;
          miss_nxt = 4'h0;
        end
      end
      // set wins over clear; fall back to fast rc
      if (fail_event)
      begin
        fail_nxt = 1'b1;
        cur_sel_nxt = SEL_FRC;
        miss_nxt = 4'h0;
      end
      if (I_WR && I_ADDR == CLK_DIV_OFS)
      begin
        post_sel_nxt = I_WDATA[POST_SEL_LSB +: 3];
      end
      if (I_WR && I_ADDR == TUNE_OFS)
      begin
        tune_nxt = I_WDATA[TUNE_W-1:0];
      end
    end
    if (I_RD)
    begin
      if (I_ADDR == OSC_CTRL_OFS)
      begin
        rdata_nxt[CUR_SEL_LSB +: 3] = cur_sel_r;
        rdata_nxt[NEW_SEL_LSB +: 3] = new_sel_r;
        rdata_nxt[FAIL_BIT] = fail_r;
        rdata_nxt[SEC_EN_BIT] = sec_en_r;
        rdata_nxt[SWITCH_BIT] = switch_r;
      end
      else if (I_ADDR == CLK_DIV_OFS)
      begin
        rdata_nxt[POST_SEL_LSB +: 3] = post_sel_r;
      end
      else if (I_ADDR == TUNE_OFS)
      begin
        rdata_nxt[TUNE_W-1:0] = tune_r;
      end
      else if (I_ADDR == MODE_STAT_OFS)
      begin
        rdata_nxt[11:0] = mode;
      end
    end
  end

  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RST_N)
    begin
      // fast rc select and standard crystal mode until configuration is caught
      cur_sel_r <= SEL_FRC;
      new_sel_r <= SEL_FRC;
      pri_mode_r <= PRI_STD;
      post_sel_r <= POST_SEL_RST;
      tune_r <= TUNE_RST;
      fail_r <= 1'b0;
      sec_en_r <= 1'b0;
      switch_r <= 1'b0;
      por_done_r <= 1'b0;
      miss_r <= 4'h0;
      rdata_r <= '0;
    end
    else
    begin
      cur_sel_r <= cur_sel_nxt;
      new_sel_r <= new_sel_nxt;
      pri_mode_r <= pri_mode_nxt;
      post_sel_r <= post_sel_nxt;
      tune_r <= tune_nxt;
      fail_r <= fail_nxt;
      sec_en_r <= sec_en_nxt;
      switch_r <= switch_nxt;
      por_done_r <= por_done_nxt;
      miss_r <= miss_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign O_RDATA = rdata_r;
  assign O_OSC_TICK = osc_tick;
  // low_power_rc_osc reference to watchdog and monitor
  assign O_WDT_REF_TICK = rise[5];
  assign O_FAIL_REF_TICK = rise[5];
  assign O_PLL_EN = (mode == CM_FRC_PLL) || (cur_sel_r == SEL_PRI_PLL);
  assign O_PLL_IN_SEL_PRI = (cur_sel_r == SEL_PRI_PLL);
  assign O_PRI_MODE = pri_mode_r;
  assign O_FAST_RC_TUNE = tune_r;
  assign O_SEC_OSC_EN = sec_en_r || (cur_sel_r == SEL_SEC);

  // ==========
  // checks
  // configuration caught once
  // sampled reset keeps the release edge itself out of the capture check
  chk_config_capture: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    I_RST_N && !por_done_r |=> (cur_sel_r == $past(I_INITIAL_OSC_SEL)))
    else $error("configuration select not captured");
  chk_mode_onehot: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    $onehot(mode))
    else $error("clock mode not unique");
  chk_fail_fallback: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    fail_event |=> fail_r && cur_sel_r == SEL_FRC)
    else $error("fail did not fall back");
  chk_pll_sources: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    O_PLL_EN |-> (O_OSC_TICK == (O_PLL_IN_SEL_PRI ? rise[3] : rise[1])))
    else $error("pll used by wrong source");
  chk_pri_mode: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    por_done_r |-> pri_mode_r != 2'h3)
    else $error("reserved primary mode");
  chk_ref_low_power_rc_osc: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    $rose(sync2_r[5]) |-> O_WDT_REF_TICK && O_FAIL_REF_TICK)
    else $error("low_power_rc_osc reference missed");
  chk_post_write: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    por_done_r && I_WR && I_ADDR == CLK_DIV_OFS |=> post_sel_r == $past(I_WDATA[10:8]))
    else $error("postscaler not written");
  chk_tune_write: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    por_done_r && I_WR && I_ADDR == TUNE_OFS |=> tune_r == $past(I_WDATA[5:0]))
    else $error("tune not written");
endmodule // scs_top

// ---- bench/test_scs_top.sv ----
// self-checking testbench for the system clock source select block
`timescale 1ns/1ns
module test_scs_top
  import scs_pkg::*;
;
  logic I_REF_CLK;
  logic I_RST_N;
  logic [5:0] src_osc;
  logic [2:0] I_INITIAL_OSC_SEL;
  logic [1:0] I_PRIMARY_OSC_MODE_SEL;
  logic [ADDR_W-1:0] I_ADDR;
  logic [DATA_W-1:0] I_WDATA;
  logic I_WR;
  logic I_RD;
  logic [DATA_W-1:0] O_RDATA;
  logic O_OSC_TICK, O_INSTR_CLK, O_INSTR_TICK, O_WDT_REF_TICK, O_FAIL_REF_TICK;
  logic O_PLL_IN_SEL_PRI, O_PLL_EN, O_SEC_OSC_EN;
  logic [1:0] O_PRI_MODE;
  logic [TUNE_W-1:0] O_FAST_RC_TUNE;
  int err_total;
  int n_tests;
  int seed;
  int n_osc, n_ins, n_wdt, n_fail;
  logic [15:0] rdv;
  int n;

  scs_top dut (
    .I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N),
    .I_FAST_RC_OSC(src_osc[0]), .I_FAST_RC_PLL(src_osc[1]),
    .I_PRIMARY_OSC(src_osc[2]), .I_PRIMARY_PLL(src_osc[3]),
    .I_SECONDARY_LOW_POWER_OSC(src_osc[4]), .I_LOW_POWER_RC_OSC(src_osc[5]),
    .I_INITIAL_OSC_SEL(I_INITIAL_OSC_SEL), .I_PRIMARY_OSC_MODE_SEL(I_PRIMARY_OSC_MODE_SEL),
    .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .O_OSC_TICK(O_OSC_TICK), .O_INSTR_CLK(O_INSTR_CLK), .O_INSTR_TICK(O_INSTR_TICK),
    .O_WDT_REF_TICK(O_WDT_REF_TICK), .O_FAIL_REF_TICK(O_FAIL_REF_TICK),
    .O_PLL_IN_SEL_PRI(O_PLL_IN_SEL_PRI), .O_PLL_EN(O_PLL_EN), .O_PRI_MODE(O_PRI_MODE),
    .O_FAST_RC_TUNE(O_FAST_RC_TUNE), .O_SEC_OSC_EN(O_SEC_OSC_EN)
  );

  // ==========
  // clock and pulse counters
  always #50 I_REF_CLK = ~I_REF_CLK;

  // counts restart at every reset so each scenario starts from zero
  always @(posedge I_REF_CLK)
  begin
    if (I_RST_N !== 1'b1)
    begin
      n_osc = 0;
      n_ins = 0;
      n_wdt = 0;
      n_fail = 0;
    end
    else
    begin
      n_osc += (O_OSC_TICK === 1'b1);
      n_ins += (O_INSTR_TICK === 1'b1);
      n_wdt += (O_WDT_REF_TICK === 1'b1);
      n_fail += (O_FAIL_REF_TICK === 1'b1);
    end
  end

  // ==========
  // tasks and expectations
  task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task do_reset(input logic [2:0] s, input logic [1:0] p);
    @(posedge I_REF_CLK);
    I_INITIAL_OSC_SEL <= s;
    I_PRIMARY_OSC_MODE_SEL <= p;
    I_RST_N <= 1'b0;
    repeat (2) @(posedge I_REF_CLK);
    I_RST_N <= 1'b1;
    repeat (2) @(posedge I_REF_CLK);
  endtask

  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge I_REF_CLK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_REF_CLK);
    I_WR <= 1'b0;
    // registers written at this edge settle just after it
    #1;
  endtask

  task rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge I_REF_CLK);
    I_RD <= 1'b1;
    I_ADDR <= a;
    @(posedge I_REF_CLK);
    I_RD <= 1'b0;
    #1 d = O_RDATA;
  endtask

  // pins are synchronised inside, so pulses stay slower than half the clock
  task tick(input int idx, input int cnt);
    repeat (cnt)
    begin
      @(posedge I_REF_CLK);
      src_osc[idx] <= 1'b1;
      repeat (2) @(posedge I_REF_CLK);
      src_osc[idx] <= 1'b0;
      repeat (2) @(posedge I_REF_CLK);
    end
    repeat (6) @(posedge I_REF_CLK);
  endtask

  function automatic logic [11:0] exp_mode(input logic [2:0] s, input logic [1:0] p);
    logic [1:0] q;
    q = (p == 2'h3) ? 2'h1 : p;
    if (s == SEL_PRI)
      return 12'h004 << q;
    if (s == SEL_PRI_PLL)
      return 12'h020 << q;
    if (s < 3'h2)
      return 12'h001 << s;
    return 12'h100 << (s - 3'h4);
  endfunction

  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========
  // watchdog
  initial
  begin
    #(20000 * 100);
    err_total++;
    give_verdict();
  end

  // ==========
  // main sequence
  initial
  begin
    I_REF_CLK = 1'b0;
    I_RST_N = 1'b0;
    src_osc = 6'h00;
    I_INITIAL_OSC_SEL = 3'h0;
    I_PRIMARY_OSC_MODE_SEL = 2'h0;
    I_ADDR = 4'h0;
    I_WDATA = 16'h0000;
    I_WR = 1'b0;
    I_RD = 1'b0;
    err_total = 0;
    n_tests = 0;
    seed = 28;
    // every configuration combination, erased 111 included
    for (int s = 0; s < 8; s++)
      for (int p = 0; p < 4; p++)
      begin
        do_reset(s[2:0], p[1:0]);
        rd(MODE_STAT_OFS, rdv);
        chk(rdv, {4'h0, exp_mode(s[2:0], p[1:0])}, "mode");
        rd(OSC_CTRL_OFS, rdv);
        chk({rdv[14:12], rdv[10:8]}, {s[2:0], s[2:0]}, "start sel");
        chk(O_PRI_MODE, (p == 3) ? 2'h1 : p[1:0], "pri mode");
        chk(O_PLL_EN, (s == 1 || s == 3), "pll en");
        if (s == 1 || s == 3)
          chk(O_PLL_IN_SEL_PRI, (s == 3), "pll in");
      end
    // register reset values, random writes, unmapped read
    do_reset(SEL_FRC, PRI_STD);
    rd(TUNE_OFS, rdv);
    chk(rdv, 16'h0000, "tune rst");
    rd(CLK_DIV_OFS, rdv);
    chk(rdv, 16'h0000, "div rst");
    rdv = 16'($random(seed)) & 16'h003f;
    n = rdv;
    wr(TUNE_OFS, rdv);
    chk(O_FAST_RC_TUNE, rdv[5:0], "tune out");
    rd(TUNE_OFS, rdv);
    chk(rdv, 16'(n), "tune rd");
    rdv = 16'($random(seed)) & 16'h0700;
    wr(CLK_DIV_OFS, rdv);
    n = rdv[10:8];
    rd(CLK_DIV_OFS, rdv);
    chk(rdv[10:8], n[2:0], "div rd");
    rd(4'hf, rdv);
    chk(rdv, 16'h0000, "unmapped");
    wr(OSC_CTRL_OFS, 16'h0002);
    chk(O_SEC_OSC_EN, 1'b1, "sec en");
    // run-time switch to every source
    for (int s = 0; s < 8; s++)
    begin
      wr(OSC_CTRL_OFS, {5'h00, s[2:0], 8'h01});
      rd(OSC_CTRL_OFS, rdv);
      chk(rdv[14:12], s[2:0], "switch");
    end
    chk(O_PLL_EN, 1'b0, "pll off");
    // instruction clock from the fast rc
    do_reset(SEL_FRC, PRI_STD);
    n = 5 + ($unsigned($random(seed)) % 8);
    tick(0, n);
    tick(2, 2);
    chk(n_osc, n, "osc ticks");
    chk(n_ins, n / 2, "instr ticks");
    chk(O_INSTR_CLK, n % 2, "instr level");
    // pll path of the primary oscillator
    do_reset(SEL_PRI_PLL, PRI_HS);
    tick(3, 4);
    tick(2, 2);
    chk(n_osc, 4, "pll ticks");
    chk(n_ins, 2, "pll instr");
    // postscaler factors on the divide-by-n source
    for (int ps = 0; ps < 4; ps++)
    begin
      do_reset(SEL_FRC_DIVN, PRI_STD);
      wr(CLK_DIV_OFS, {5'h00, ps[2:0], 8'h00});
      tick(0, 16);
      chk(n_osc, 16 >> ps, "postscale");
    end
    do_reset(SEL_FRC_DIV16, PRI_STD);
    tick(0, 32);
    chk(n_osc, 2, "div16");
    // primary stopped: reference ticks raise the fail flag
    do_reset(SEL_PRI, PRI_HS);
    tick(5, FAIL_LIMIT);
    chk(n_wdt, FAIL_LIMIT, "wdt ref");
    chk(n_fail, FAIL_LIMIT, "fail ref");
    rd(OSC_CTRL_OFS, rdv);
    chk({rdv[14:12], rdv[FAIL_BIT]}, {SEL_FRC, 1'b1}, "fail set");
    wr(OSC_CTRL_OFS, 16'h0000);
    rd(OSC_CTRL_OFS, rdv);
    chk(rdv[FAIL_BIT], 1'b0, "fail clr");
    give_verdict();
  end
endmodule // test_scs_top
